/* design/gcf_cfg.svh */
`ifndef GCF_CFG_SVH
`define GCF_CFG_SVH
// register indices
`define GCF_IDX_FLAGS 7'h01
// the only indices the host may write
`define GCF_IDX_WR_CHARGE 7'h03
`define GCF_IDX_WR_PACK_ID 7'h04
`define GCF_IDX_WR_CAPACITY 7'h05
`define GCF_IDX_WR_FILTER 7'h0A
// command byte fields
`define GCF_CMD_DIR_BIT 7
// flag bit positions in the primary flag register
`define GCF_BIT_CHARGING_DETECTED_FLAG 7
`define GCF_BIT_SWAP 6
`define GCF_BIT_ABSENT 5
`define GCF_BIT_STALE 4
`define GCF_BIT_DQUAL 3
`define GCF_BIT_PERMIT 2
`define GCF_BIT_LOWV 1
`define GCF_BIT_DEPL 0
// reset value: swap and stale set by a device reset
`define GCF_FLAGS_RST 8'h50
// counts
`define GCF_STALE_CHARGES 7'h40
`define GCF_LEAK_CEILING 16'h1000
`define GCF_QUAL_CHARGE_COUNTS 9'h100
// blink: 4 Hz blink means a toggle every 125 ms
`define GCF_CLK_HZ 10000000
`define GCF_BLINK_HZ 4
`define GCF_BLINK_CYCLES (`GCF_CLK_HZ / (`GCF_BLINK_HZ * 2))
`endif

/* design/gcf_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gcf_cfg.svh"
// Functional notes
// - command taken after eight complete bits
// - direction 0 sends the indexed register
// - direction 1 stores following byte
// - index is command bits six to zero
// - writes to invalid indices are dropped
// - charging flag follows offset sense threshold while not discharging
// - swap set by pack edges or reset
// - swap cleared by charge at full or charge after warning
// - absent flag tracks out-of-window pack voltage
// - stale set on 64th charge, cleared update
// - qualified set on discharge from full
// - qualified cleared when leak count exceeds ceiling
// - qualified cleared by 256-count sustained charge
// - qualified cleared by cold low-voltage warning
// - permit flag mirrors permit output inverted
// - low-voltage warning latched until valid charge
// - first segment blinks 4Hz under warning
// - depletion fault latched, segments off
// - depleted output released on warning
// - bytes travel least significant bit first
module gcf_core
  import gcf_pkg::*;
#(
  parameter int BLINK_CYCLES = `GCF_BLINK_CYCLES,
  parameter int SEG_COUNT = 6
)
(
  input wire logic sys_clk,
  input wire logic rst,
  // bytes from the bit-level receiver, lsb-first already assembled
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic [7:0] command_byte_register,
  output logic wr_strobe,
  output logic [6:0] wr_index,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_ext_data,
  // comparator and counter events, asynchronous levels
  input wire logic above_charge_detect_pin,
  input wire logic discharge_active_pin,
  input wire logic pack_above_ceiling_pin,
  input wire logic pack_below_floor_pin,
  input wire logic pack_below_warn_pin,
  input wire logic pack_below_fault_pin,
  input wire logic overcurrent_flag_pin,
  input wire logic below_zero_c_pin,
  // same-clock events from the capacity arithmetic
  input wire logic valid_charge,
  input wire logic charge_count_pulse,
  input wire logic discharge_start,
  input wire logic full_reached,
  input wire logic capacity_update,
  input wire logic [15:0] self_leak_count,
  input wire logic charge_permit_output,
  input wire logic display_enable,
  input wire logic [SEG_COUNT-1:0] seg_gauge,
  output logic [7:0] primary_flag_register,
  output logic [SEG_COUNT-1:0] seg_out,
  output logic depleted_oe
);

  localparam int NSYNC = 8;
  logic [NSYNC-1:0] pin_raw, sync1_q, sync2_q, prev_q;
  assign pin_raw = {below_zero_c_pin, overcurrent_flag_pin, pack_below_fault_pin, pack_below_warn_pin,
                    pack_below_floor_pin, pack_above_ceiling_pin, discharge_active_pin,
                    above_charge_detect_pin};

  // two-stage synchronisers, one per comparator pin
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end
        else
        begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          prev_q[gi] <= sync2_q[gi];
        end
      end
    end
  endgenerate

  logic above_thr, dischg, above_ceil, below_floor, below_warn, below_fault, overcurrent_flag, cold;
  assign {cold, overcurrent_flag, below_fault, below_warn, below_floor, above_ceil, dischg, above_thr} = sync2_q;
  logic fall_from_ceil, rise_from_floor;
  assign fall_from_ceil = prev_q[2] && !above_ceil;
  assign rise_from_floor = prev_q[3] && !below_floor;

  // command decoder
  gcf_state_t st_q, st_d;
  logic [7:0] cmd_q, cmd_d, txb_q, txb_d;
  logic wr_q, wr_d;
  logic [7:0] wdat_q, wdat_d;
  logic idx_ok;

  // only indices the register map knows may be written; the flag register is never writable
  // reject invalid
  assign idx_ok = (cmd_q[6:0] == `GCF_IDX_WR_CHARGE) || (cmd_q[6:0] == `GCF_IDX_WR_PACK_ID)
                  || (cmd_q[6:0] == `GCF_IDX_WR_CAPACITY) || (cmd_q[6:0] == `GCF_IDX_WR_FILTER);

  always_comb
  begin
    st_d = st_q;
    cmd_d = cmd_q;
    txb_d = txb_q;
    wr_d = 1'b0;
    wdat_d = wdat_q;
    unique case (st_q)
      GCF_IDLE:
      begin
        if (rx_valid)
        begin
          cmd_d = rx_byte;
          if (rx_byte[`GCF_CMD_DIR_BIT])
            st_d = GCF_WDATA;
          else
          begin
            st_d = GCF_SEND;
            txb_d = (rx_byte[6:0] == `GCF_IDX_FLAGS) ? primary_flag_register : rd_ext_data;
          end
        end
      end
      GCF_WDATA:
      begin
        if (rx_valid)
        begin
          st_d = GCF_IDLE;
          wdat_d = rx_byte;
          wr_d = idx_ok;
        end
      end
      GCF_SEND:
      begin
        if (tx_ready)
          st_d = GCF_IDLE;
      end
      default: st_d = GCF_IDLE;
    endcase
  end

  // decoder state registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_q <= GCF_IDLE;
      cmd_q <= 8'h00;
      txb_q <= 8'h00;
      wr_q <= 1'b0;
      wdat_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      txb_q <= txb_d;
      wr_q <= wr_d;
      wdat_q <= wdat_d;
    end
  end

  // the bit serialiser outside sends tx_byte lsb first
  // lsb first
  assign tx_valid = (st_q == GCF_SEND);
  assign tx_byte = txb_q;
  assign command_byte_register = cmd_q;
  assign wr_strobe = wr_q;
  assign wr_index = cmd_q[6:0];
  assign wr_data = wdat_q;

  // flag state
  logic [7:0] fl_q, fl_d;
  logic [6:0] stale_cnt_q, stale_cnt_d;
  logic [8:0] qchg_q, qchg_d;
  logic dq_armed_q, dq_armed_d;

  always_comb
  begin
    fl_d = fl_q;
    stale_cnt_d = stale_cnt_q;
    qchg_d = qchg_q;
    dq_armed_d = dq_armed_q;
    fl_d[`GCF_BIT_CHARGING_DETECTED_FLAG] = above_thr && !dischg;
    fl_d[`GCF_BIT_ABSENT] = above_ceil || below_floor;
    fl_d[`GCF_BIT_PERMIT] = !charge_permit_output;
    if (valid_charge)
      fl_d[`GCF_BIT_LOWV] = 1'b0;
    if (below_warn && !overcurrent_flag)
      fl_d[`GCF_BIT_LOWV] = 1'b1;
    if (valid_charge)
      fl_d[`GCF_BIT_DEPL] = 1'b0;
    if (below_fault && !overcurrent_flag)
      fl_d[`GCF_BIT_DEPL] = 1'b1;
    if ((valid_charge && full_reached) || (valid_charge && fl_q[`GCF_BIT_LOWV]))
      fl_d[`GCF_BIT_SWAP] = 1'b0;
    if (fall_from_ceil || rise_from_floor)
      fl_d[`GCF_BIT_SWAP] = 1'b1;
    // stale counter saturates at the trigger count
    if (capacity_update)
    begin
      stale_cnt_d = 7'h00;
      fl_d[`GCF_BIT_STALE] = 1'b0;
    end
    else if (valid_charge && stale_cnt_q != `GCF_STALE_CHARGES)
    begin
      stale_cnt_d = stale_cnt_q + 7'h01;
      if (stale_cnt_d == `GCF_STALE_CHARGES)
        fl_d[`GCF_BIT_STALE] = 1'b1;
    end
    // sustained-charge counter restarts whenever the charge drops below threshold
    if (!above_thr)
      qchg_d = 9'h000;
    else if (charge_count_pulse && qchg_q != `GCF_QUAL_CHARGE_COUNTS)
      qchg_d = qchg_q + 9'h001;
    // arm on full, set on first discharge
    if (full_reached)
      dq_armed_d = 1'b1;
    if (discharge_start && (dq_armed_q || full_reached))
    begin
      fl_d[`GCF_BIT_DQUAL] = 1'b1;
      dq_armed_d = 1'b0;
    end
    if (self_leak_count > `GCF_LEAK_CEILING || qchg_q == `GCF_QUAL_CHARGE_COUNTS
        || (!fl_q[`GCF_BIT_LOWV] && fl_d[`GCF_BIT_LOWV] && cold) || capacity_update)
      fl_d[`GCF_BIT_DQUAL] = 1'b0;
  end

  // flag registers; reset sets swap and stale
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      fl_q <= `GCF_FLAGS_RST;
      stale_cnt_q <= 7'h00;
      qchg_q <= 9'h000;
      dq_armed_q <= 1'b0;
    end
    else
    begin
      fl_q <= fl_d;
      stale_cnt_q <= stale_cnt_d;
      qchg_q <= qchg_d;
      dq_armed_q <= dq_armed_d;
    end
  end
  assign primary_flag_register = fl_q;

  // blink divider toggles the segment phase
  logic [31:0] bl_cnt_q, bl_cnt_d;
  logic bl_ph_q, bl_ph_d;
  always_comb
  begin
    bl_cnt_d = bl_cnt_q + 32'h1;
    bl_ph_d = bl_ph_q;
    if (bl_cnt_q == 32'(BLINK_CYCLES - 1))
    begin
      bl_cnt_d = 32'h0;
      bl_ph_d = !bl_ph_q;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      bl_cnt_q <= 32'h0;
      bl_ph_q <= 1'b0;
    end
    else
    begin
      bl_cnt_q <= bl_cnt_d;
      bl_ph_q <= bl_ph_d;
    end
  end

  // segment drivers; fault blanks everything
  always_comb
  begin
    seg_out = display_enable ? seg_gauge : '0;
    if (display_enable && fl_q[`GCF_BIT_LOWV])
      seg_out[0] = bl_ph_q;
    if (fl_q[`GCF_BIT_DEPL])
      seg_out = '0;
  end

  assign depleted_oe = !fl_q[`GCF_BIT_LOWV];

  // a_absent_tracks: absent flag follows the window one cycle later
  a_absent_tracks: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> fl_q[`GCF_BIT_ABSENT] == $past(above_ceil || below_floor)) else $error("absent flag wrong");
  a_write_invalid: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == GCF_WDATA && rx_valid && !idx_ok) |=> !wr_strobe) else $error("invalid write strobed");
  a_read_reply: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == GCF_IDLE && rx_valid && !rx_byte[7]) |=> tx_valid) else $error("no reply");
  a_lowv_latch: assert property (@(posedge sys_clk) disable iff (rst)
    (fl_q[`GCF_BIT_LOWV] && !valid_charge) |=> fl_q[`GCF_BIT_LOWV]) else $error("warning lost");
  a_depl_blank: assert property (@(posedge sys_clk) disable iff (rst)
    fl_q[`GCF_BIT_DEPL] |-> seg_out == '0) else $error("segments on in fault");
  a_empty_release: assert property (@(posedge sys_clk) disable iff (rst)
    (below_warn && !overcurrent_flag) |=> !depleted_oe) else $error("depleted pin driven");
  a_swap_set: assert property (@(posedge sys_clk) disable iff (rst)
    (fall_from_ceil || rise_from_floor) |=> fl_q[`GCF_BIT_SWAP]) else $error("swap not set");
  a_permit_mirror: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> fl_q[`GCF_BIT_PERMIT] == !$past(charge_permit_output)) else $error("permit flag wrong");
endmodule // gcf_core
`default_nettype wire

/* design/gcf_pkg.sv */
`default_nettype none
package gcf_pkg;
  typedef enum logic [1:0] {
    GCF_IDLE = 2'b00,
    GCF_WDATA = 2'b01,
    GCF_SEND = 2'b11
  } gcf_state_t;
endpackage
`default_nettype wire

/* verification/gcf_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin failures++; $display("wrong value %s exp %h got %h", n, e, a); end end
module gcf_core_tb;
  localparam int BC = 10;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic rx_valid, tx_ready, tx_valid, wr_strobe, depleted_oe, last, vc, ccp, dst, full, cupd, cpo, den;
  logic [7:0] rx_byte, tx_byte, cmd, wr_data, flags, ext, got, pins;
  logic [6:0] wr_index;
  logic [5:0] seg_g, seg_out;
  logic [15:0] leak;
  logic [6:0] widx [4] = '{7'h03, 7'h04, 7'h05, 7'h0A};
  int failures = 0;
  int compares = 0;
  int strobes = 0;
  int n;
  bit ok;

  always #50 sys_clk = ~sys_clk;

  gcf_core #(.BLINK_CYCLES(BC)) gcf_core_inst (.sys_clk(sys_clk), .rst(rst), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .command_byte_register(cmd), .wr_strobe(wr_strobe), .wr_index(wr_index), .wr_data(wr_data),
    .rd_ext_data(ext), .above_charge_detect_pin(pins[0]), .discharge_active_pin(pins[1]),
    .pack_above_ceiling_pin(pins[2]), .pack_below_floor_pin(pins[3]), .pack_below_warn_pin(pins[4]),
    .pack_below_fault_pin(pins[5]), .overcurrent_flag_pin(pins[6]), .below_zero_c_pin(pins[7]),
    .valid_charge(vc), .charge_count_pulse(ccp), .discharge_start(dst), .full_reached(full),
    .capacity_update(cupd), .self_leak_count(leak), .charge_permit_output(cpo), .display_enable(den),
    .seg_gauge(seg_g), .primary_flag_register(flags), .seg_out(seg_out), .depleted_oe(depleted_oe));

  gcf_host_model host_inst (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte));

  // count write strobes as the design emits them
  always @(posedge sys_clk)
    if (wr_strobe === 1'b1)
      strobes++;

  // expected flag byte: permit bit comes from the permit level
  function automatic logic [7:0] fx(input logic [6:0] f);
    return {f[6:2], ~cpo, f[1:0]};
  endfunction

  task automatic complete_run();
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #5;
  endtask

  // pulse with a gap so the strobe never changes twice in one step
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [6:0] i, input logic [7:0] e);
    `CHK("early reply", 1'b0, tx_valid)
    host_inst.send({1'b0, i});
    host_inst.take(got, ok);
    `CHK("read", e, got)
    `CHK("command", {1'b0, i}, cmd)
    if (!ok)
    begin
      failures++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [6:0] i, input logic [7:0] d, input int hit);
    int s;
    s = strobes;
    host_inst.send({1'b1, i});
    host_inst.send(d);
    cyc(2);
    `CHK("strobes", s + hit, strobes)
    if (hit == 1)
      `CHK("write", {i, d}, {wr_index, wr_data})
  endtask

  // watchdog for a hung run
  initial
  begin
    #3000000;
    failures++;
    complete_run();
  end

  initial
  begin
    {pins, vc, ccp, dst, full, cupd, leak, ext} = '0;
    cpo = 1'b1;
    den = 1'b1;
    seg_g = 6'h3F;
    void'($urandom(32'hCA0C));
    cyc(3);
    rst = 1'b0;
    cyc(1);
    rd(7'h01, fx(7'h28));
    `CHK("segments", seg_g, seg_out)
    cpo = 1'b0;
    cyc(2);
    rd(7'h01, fx(7'h28));
    for (int i = 0; i < 6; i++)
    begin
      ext = 8'($urandom);
      rd(7'($urandom_range(2, 127)), ext);
    end
    foreach (widx[i]) wr(widx[i], 8'($urandom), 1);
    wr(7'h01, 8'hFF, 0);
    wr(7'($urandom_range(11, 127)), 8'hA5, 0);
    rd(7'h01, fx(7'h28));
    // ceiling then floor excursions
    for (int j = 2; j < 4; j++)
    begin
      full = 1'b1;
      pulse(vc);
      full = 1'b0;
      pins[j] = 1'b1;
      cyc(5);
      rd(7'h01, fx(7'h18));
      pins[j] = 1'b0;
      cyc(5);
      rd(7'h01, fx(7'h28));
    end
    pins[0] = 1'b1;
    cyc(5);
    rd(7'h01, fx(7'h68));
    pins[1] = 1'b1;
    cyc(5);
    rd(7'h01, fx(7'h28));
    `CHK("depleted drive", 1'b1, depleted_oe)
    pins = 8'h10;
    cyc(5);
    `CHK("depleted drive", 1'b0, depleted_oe)
    n = 0;
    for (int i = 0; i < 4 * BC; i++)
    begin
      last = seg_out[0];
      cyc(1);
      n += int'(seg_out[0] !== last);
    end
    `CHK("blink toggles", 4, n)
    den = 1'b0;
    cyc(1);
    `CHK("display off", 6'h00, seg_out)
    den = 1'b1;
    pins = 8'h00;
    cyc(5);
    rd(7'h01, fx(7'h2A));
    pins = 8'h30;
    cyc(5);
    `CHK("segments", 6'h00, seg_out)
    rd(7'h01, fx(7'h2B));
    pins = 8'h00;
    cyc(5);
    pulse(vc);
    rd(7'h01, fx(7'h08));
    pins = 8'h50;
    cyc(5);
    rd(7'h01, fx(7'h08));
    pins = 8'h00;
    pulse(cupd);
    rd(7'h01, fx(7'h00));
    repeat (63) pulse(vc);
    rd(7'h01, fx(7'h00));
    pulse(vc);
    rd(7'h01, fx(7'h08));
    full = 1'b1;
    pulse(dst);
    full = 1'b0;
    rd(7'h01, fx(7'h0C));
    leak = 16'h1001;
    cyc(2);
    leak = 16'h0000;
    rd(7'h01, fx(7'h08));
    full = 1'b1;
    pulse(dst);
    full = 1'b0;
    pins[0] = 1'b1;
    cyc(5);
    rd(7'h01, fx(7'h4C));
    repeat (256) pulse(ccp);
    rd(7'h01, fx(7'h48));
    pins[0] = 1'b0;
    cyc(5);
    full = 1'b1;
    pulse(dst);
    full = 1'b0;
    rd(7'h01, fx(7'h0C));
    pins = 8'h90;
    cyc(5);
    rd(7'h01, fx(7'h0A));
    complete_run();
  end
endmodule // gcf_core_tb
`default_nettype wire

/* verification/gcf_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host side of the byte link; the bit serialiser is outside the block
module gcf_host_model (
  input wire logic sys_clk,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte
);
  // cycles to stall before taking a reply; a slow host is legal
  int stall = 0;

  initial
  begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
  end

  // whole bytes only
  // released byte shows the inverse so a stale value never matches
  task automatic send(input logic [7:0] b);
    @(posedge sys_clk);
    #5;
    rx_valid = 1'b1;
    rx_byte = b;
    @(posedge sys_clk);
    #5;
    rx_valid = 1'b0;
    rx_byte = ~b;
  endtask

  // bounded wait for the reply, held until accepted
  task automatic take(output logic [7:0] b, output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++)
    begin
      @(posedge sys_clk);
      #5;
      if (n >= stall && tx_valid === 1'b1)
      begin
        tx_ready = 1'b1;
        b = tx_byte;
        @(posedge sys_clk);
        #5;
        tx_ready = 1'b0;
        ok = 1'b1;
      end
    end
  endtask
endmodule // gcf_host_model
`default_nettype wire
